//--- mcsp_pkg.sv
/*
  Constants of the main clock select and prescale block: register
  offsets, field positions, reset values, source codes and timing.
  Assumes an 8-bit register port with a 5-bit address.
*/
package mcsp_pkg;
  localparam logic [4:0] OFS_SRC_CTRL = 5'h00;
  localparam logic [4:0] OFS_PRESCALE = 5'h01;
  localparam logic [4:0] OFS_FREEZE = 5'h02;
  localparam logic [4:0] OFS_STATUS = 5'h03;
  localparam logic [4:0] OFS_FRC_CTRL = 5'h10;
  localparam logic [4:0] OFS_FRC_FTRIM = 5'h11;
  localparam logic [4:0] OFS_FRC_TTRIM = 5'h12;
  localparam int CLK_OUT_EN_POS = 7;
  localparam int PRESC_EN_POS = 0;
  localparam int FREEZE_POS = 0;
  localparam int KEEP_RUN_POS = 1;
  localparam int CAL_LOCK_POS = 7;
  localparam logic [7:0] SRC_CTRL_RST = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'h11;
  localparam logic [7:0] FREEZE_RST = 8'h00;
  localparam logic [7:0] FRC_CTRL_RST = 8'h00;
  localparam logic [1:0] SRC_FRC = 2'h0;
  localparam logic [1:0] SRC_ULP = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [2:0] FRC_GATE_CYCLES = 3'h4;
  typedef enum logic {SW_IDLE, SW_WAIT} mcsp_sw_t;
  // Division ratio of a divide code; zero marks a reserved code.
  function automatic logic [6:0] mcsp_ratio(input logic [3:0] code);
    case (code)
      4'h0: mcsp_ratio = 7'h02;
      4'h1: mcsp_ratio = 7'h04;
      4'h2: mcsp_ratio = 7'h08;
      4'h3: mcsp_ratio = 7'h10;
      4'h4: mcsp_ratio = 7'h20;
      4'h5: mcsp_ratio = 7'h40;
      4'h8: mcsp_ratio = 7'h06;
      4'h9: mcsp_ratio = 7'h0A;
      4'hA: mcsp_ratio = 7'h0C;
      4'hB: mcsp_ratio = 7'h18;
      4'hC: mcsp_ratio = 7'h30;
      default: mcsp_ratio = 7'h00;
    endcase
  endfunction
endpackage

//--- mcsp_prescaler.sv
/*
  Prescaler that turns the main clock into a peripheral clock enable.
  Assumes the main clock is the clock of this module.
*/
`timescale 1ns/1ps
module mcsp_prescaler
  import mcsp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic presc_en_i,
  input wire logic [3:0] div_code_i,
  output logic tick_o
);
  import mcsp_pkg::*;
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } mcsp_div_st_t;
  mcsp_div_st_t st_r;
  mcsp_div_st_t st_nxt;
  logic [6:0] ratio;

  always_comb
  begin
    st_nxt = st_r;
    ratio = mcsp_ratio(div_code_i);
    if (!presc_en_i || ratio == 7'h00)
    begin
      // Reserved codes fall back to undivided operation.
      st_nxt.cnt = 7'h00;
      st_nxt.tick = 1'b1;
    end
    else if (st_r.cnt >= ratio - 7'h01)
    begin
      // A code changed on the fly takes effect at once; a count already at or past the new end wraps in the next cycle.
      st_nxt.cnt = 7'h00;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 7'h01;
      st_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_o = st_r.tick;
endmodule

//--- mcsp_sva.sv
/*
  Port assertions of the main clock select and prescale block.
  Assumes it is bound to every mcsp_top instance.
*/
`timescale 1ns/1ps
module mcsp_sva (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic key_window_i,
  input wire logic sleep_i,
  input wire logic sysclk_used_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] main_src_o,
  input wire logic clk_out_oe_o,
  input wire logic frc_run_o,
  input wire logic frc_gate_o,
  input wire logic [5:0] frc_ftrim_o,
  input wire logic [3:0] frc_ttrim_o,
  input wire logic [3:0] src_req_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  rd_hole_a: assert property (
    rd_i && addr_i inside {[5'h04:5'h0F]} |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  out_sleep_a: assert property (
    sleep_i && !sysclk_used_i |=> !clk_out_oe_o)
    else $error("clock out in sleep");
  gate_req_a: assert property (
    !src_req_o[0] [*2] |-> !frc_gate_o)
    else $error("gate open without request");
  gate_wait_a: assert property (
    $rose(src_req_o[0]) |-> !frc_gate_o [*4])
    else $error("gate opened early");
  gate_run_a: assert property (frc_gate_o |-> frc_run_o)
    else $error("gate open with oscillator off");
  switch_req_a: assert property (
    $changed(main_src_o) |-> src_req_o[main_src_o])
    else $error("switch to unrequested source");
  trim_hold_a: assert property (
    $past(arst_n_i, 2) && !($past(wr_i) && $past(key_window_i))
    |-> $stable({frc_ftrim_o, frc_ttrim_o}))
    else $error("trim changed without write");
endmodule

bind mcsp_top mcsp_sva u_sva (.*);

//--- mcsp_top.sv
/*
  Main clock select and prescale control: source selection with a
  glitch-free switch, prescaler, clock-out gating, freeze, fast RC
  oscillator control and trims, and the status register.
  Assumes a single-cycle register port, a key window flag from the
  processor on the same clock, fuse values stable around reset and
  oscillator ready levels arriving asynchronously.
*/
`timescale 1ns/1ps
module mcsp_top
  import mcsp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic key_window_i,
  input wire logic sleep_i,
  input wire logic sysclk_used_i,
  input wire logic [3:0] module_req_i,
  input wire logic [3:0] osc_ready_i,
  input wire logic fuse_freq_sel_i,
  input wire logic fuse_cal_lock_i,
  input wire logic [5:0] fuse_ftrim16_i,
  input wire logic [5:0] fuse_ftrim20_i,
  input wire logic [3:0] fuse_ttrim16_i,
  input wire logic [3:0] fuse_ttrim20_i,
  output logic [1:0] main_src_o,
  output logic per_clk_en_o,
  output logic clk_out_oe_o,
  output logic frc_run_o,
  output logic frc_gate_o,
  output logic [5:0] frc_ftrim_o,
  output logic [3:0] frc_ttrim_o,
  output logic [3:0] src_req_o
);
  import mcsp_pkg::*;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic clk_out_en;
    logic [1:0] target;
    logic [1:0] cur;
    logic [3:0] div_code;
    logic presc_en;
    logic freeze;
    logic keep_run;
    logic [5:0] ftrim;
    logic [3:0] ttrim;
    logic cal_lock;
    logic loaded;
    logic ext_started;
    mcsp_sw_t sw;
    logic [2:0] frc_cnt;
    logic frc_gate;
    logic frc_run;
    logic clk_oe;
    logic [3:0] req;
    logic [7:0] rdata;
  } mcsp_st_t;

  mcsp_st_t st_r;
  mcsp_st_t st_nxt;
  logic [3:0] req;
  logic [3:0] stable;
  logic target_ok;
  logic wr_ok;
  logic frc_cal_frozen;
  logic [7:0] status;

  // Sources wanted by the main clock, a pending switch or a module.
  always_comb
  begin
    req = module_req_i;
    req[st_r.cur] = 1'b1;
    if (st_r.sw == SW_WAIT)
      req[st_r.target] = 1'b1;
  end

  always_comb
  begin
    stable = st_r.sync2 & st_r.req;
    stable[SRC_FRC] = st_r.frc_gate & st_r.req[SRC_FRC];
    target_ok = stable[st_r.target];
    wr_ok = wr_i && key_window_i && st_r.loaded;
    frc_cal_frozen = st_r.cal_lock ||
      (st_r.freeze && st_r.cur == SRC_FRC);
    status = {st_r.ext_started, stable[SRC_XTAL], stable[SRC_ULP],
      stable[SRC_FRC], 3'h0, st_r.sw == SW_WAIT};
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync1 = osc_ready_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.req = req;

    // Fuse values are taken once, in the first cycle after reset.
    if (!st_r.loaded)
    begin
      st_nxt.loaded = 1'b1;
      st_nxt.cal_lock = fuse_cal_lock_i;
      st_nxt.ftrim = fuse_freq_sel_i ? fuse_ftrim20_i
        : fuse_ftrim16_i;
      st_nxt.ttrim = fuse_freq_sel_i ? fuse_ttrim20_i
        : fuse_ttrim16_i;
    end

    if (wr_ok)
    begin
      case (addr_i)
        OFS_SRC_CTRL:
        begin
          if (!st_r.freeze)
          begin
            st_nxt.clk_out_en = wdata_i[CLK_OUT_EN_POS];
            st_nxt.target = wdata_i[1:0];
            if (wdata_i[1:0] != st_r.cur)
              st_nxt.sw = SW_WAIT;
          end
        end
        OFS_PRESCALE:
        begin
          if (!st_r.freeze)
          begin
            st_nxt.div_code = wdata_i[4:1];
            st_nxt.presc_en = wdata_i[PRESC_EN_POS];
          end
        end
        OFS_FREEZE:
        begin
          if (!st_r.freeze)
            st_nxt.freeze = wdata_i[FREEZE_POS];
        end
        OFS_FRC_CTRL:
          st_nxt.keep_run = wdata_i[KEEP_RUN_POS];
        OFS_FRC_FTRIM:
        begin
          if (!frc_cal_frozen)
            st_nxt.ftrim = wdata_i[5:0];
        end
        OFS_FRC_TTRIM:
        begin
          if (!frc_cal_frozen)
            st_nxt.ttrim = wdata_i[3:0];
        end
        default:
          st_nxt.rdata = st_r.rdata;
      endcase
    end

    // The old source stays selected until the new one is stable.
    case (st_r.sw)
      SW_IDLE:
        st_nxt.target = (wr_ok && addr_i == OFS_SRC_CTRL && !st_r.freeze)
          ? wdata_i[1:0] : st_r.cur;
      SW_WAIT:
      begin
        if (st_r.target == st_r.cur)
          st_nxt.sw = SW_IDLE;
        else if (target_ok)
        begin
          st_nxt.cur = st_r.target;
          st_nxt.sw = SW_IDLE;
        end
      end
      default:
        st_nxt.sw = SW_IDLE;
    endcase

    if (stable[SRC_EXT])
      st_nxt.ext_started = 1'b1;

    // Fast RC: the gate opens a fixed count after a request, and the
    // analog start-up wait is skipped when it is kept running.
    st_nxt.frc_run = st_r.keep_run || req[SRC_FRC];
    if (!req[SRC_FRC])
    begin
      st_nxt.frc_cnt = 3'h0;
      st_nxt.frc_gate = 1'b0;
    end
    else if (st_r.frc_cnt == FRC_GATE_CYCLES)
      st_nxt.frc_gate = 1'b1;
    else if (st_r.sync2[SRC_FRC] || st_r.keep_run)
      st_nxt.frc_cnt = st_r.frc_cnt + 3'h1;

    st_nxt.clk_oe = st_r.clk_out_en && (!sleep_i || sysclk_used_i);

    st_nxt.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        OFS_SRC_CTRL:
          st_nxt.rdata = {st_r.clk_out_en, 5'h00, st_r.target};
        OFS_PRESCALE:
          st_nxt.rdata = {3'h0, st_r.div_code, st_r.presc_en};
        OFS_FREEZE:
          st_nxt.rdata = st_r.freeze ? 8'h00 : 8'h00;
        OFS_STATUS:
          st_nxt.rdata = status;
        OFS_FRC_CTRL:
          st_nxt.rdata = {6'h00, st_r.keep_run, 1'b0};
        OFS_FRC_FTRIM:
          st_nxt.rdata = {2'h0, st_r.ftrim};
        OFS_FRC_TTRIM:
          st_nxt.rdata = {st_r.cal_lock, 3'h0, st_r.ttrim};
        default:
          st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
      st_r.clk_out_en <= SRC_CTRL_RST[CLK_OUT_EN_POS];
      st_r.target <= SRC_CTRL_RST[1:0];
      st_r.cur <= SRC_CTRL_RST[1:0];
      st_r.div_code <= PRESCALE_RST[4:1];
      st_r.presc_en <= PRESCALE_RST[PRESC_EN_POS];
      st_r.freeze <= FREEZE_RST[FREEZE_POS];
      st_r.keep_run <= FRC_CTRL_RST[KEEP_RUN_POS];
      st_r.sw <= SW_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  mcsp_prescaler u_prescaler
  (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .presc_en_i(st_r.presc_en),
    .div_code_i(st_r.div_code),
    .tick_o(per_clk_en_o)
  );

  assign rdata_o = st_r.rdata;
  assign main_src_o = st_r.cur;
  assign clk_out_oe_o = st_r.clk_oe;
  assign frc_run_o = st_r.frc_run;
  assign frc_gate_o = st_r.frc_gate;
  assign frc_ftrim_o = st_r.ftrim;
  assign frc_ttrim_o = st_r.ttrim;
  assign src_req_o = st_r.req;
endmodule

//--- testbench.sv
/*
  Self-checking bench of mcsp_top.
  Drives register port, fuses and oscillator levels itself.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  logic sys_clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0;
  logic key_window_i = 1, sleep_i = 0, sysclk_used_i = 0;
  logic fuse_freq_sel_i = 1, fuse_cal_lock_i = 0;
  logic [4:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o;
  logic [3:0] module_req_i = 0, osc_ready_i = 4'hF;
  logic [3:0] fuse_ttrim16_i, fuse_ttrim20_i, frc_ttrim_o, src_req_o;
  logic [5:0] fuse_ftrim16_i, fuse_ftrim20_i, frc_ftrim_o;
  logic [1:0] main_src_o, s, p;
  logic per_clk_en_o, clk_out_oe_o, frc_run_o, frc_gate_o;
  int error_cnt = 0, checked = 0, n;
  integer seed = 32'h242f;
  localparam int RT[16] = '{2,4,8,16,32,64,1,1,6,10,12,24,48,1,1,1};
  mcsp_top DUT (.*);
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rst;
    arst_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o & m, e)
  endtask
  // Cycles between two peripheral clock enables.
  task automatic gap(output int g);
    for (int i = 0; i < 200 && per_clk_en_o !== 1'b1; i++)
      @(negedge sys_clk_i);
    g = 0;
    do
    begin
      @(negedge sys_clk_i);
      g++;
    end
    while (per_clk_en_o !== 1'b1 && g < 200);
  endtask
  initial
  begin
    {fuse_ftrim16_i, fuse_ftrim20_i, fuse_ttrim16_i, fuse_ttrim20_i} =
      20'($random(seed));
    rst();
    `CHK(frc_ftrim_o, fuse_ftrim20_i)
    `CHK(frc_ttrim_o, fuse_ttrim20_i)
    rd(5'h00, 8'h00);
    rd(5'h01, 8'h11);
    rd(5'h02, 8'h00);
    rd(5'h03, 8'h00, 8'h81);
    rd(5'h10, 8'h00);
    rd(5'h11, {2'h0, fuse_ftrim20_i});
    rd(5'h12, {4'h0, fuse_ttrim20_i});
    rd(5'h07, 8'h00);
    $display("reset values done");
    for (int c = 0; c < 16; c++)
    begin
      wr(5'h01, {3'h7, 4'(c), 1'b1});
      rd(5'h01, {3'h0, 4'(c), 1'b1});
      gap(n);
      gap(n);
      `CHK(n, RT[c])
    end
    wr(5'h01, 8'h0A);
    gap(n);
    gap(n);
    `CHK(n, 1)
    key_window_i <= 1'b0;
    wr(5'h01, 8'h03);
    key_window_i <= 1'b1;
    rd(5'h01, 8'h0A);
    $display("prescaler done");
    wr(5'h00, 8'h80);
    repeat (2) @(posedge sys_clk_i);
    `CHK(clk_out_oe_o, 1'b1)
    sleep_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    `CHK(clk_out_oe_o, 1'b0)
    sysclk_used_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    `CHK(clk_out_oe_o, 1'b1)
    sleep_i <= 1'b0;
    $display("clock out done");
    p = 2'h0;
    for (int i = 1; i < 5; i++)
    begin
      s = 2'(i);
      osc_ready_i[s] <= 1'b0;
      wr(5'h00, {6'h0, s});
      rd(5'h03, 8'h01, 8'h01);
      `CHK(main_src_o, p)
      osc_ready_i[s] <= 1'b1;
      for (n = 0; n < 40 && main_src_o !== s; n++)
        @(posedge sys_clk_i);
      `CHK(main_src_o, s)
      rd(5'h03, {1'b0, s == 2'h2, s == 2'h1, 5'h0}, 8'h61);
      if (s == 2'h3)
        rd(5'h03, 8'h80, 8'h80);
      if (s == 2'h1)
      begin
        repeat (3) @(posedge sys_clk_i);
        `CHK(frc_gate_o, 1'b0)
        wr(5'h10, 8'hFF);
        rd(5'h10, 8'h02);
        repeat (2) @(posedge sys_clk_i);
        `CHK({frc_run_o, frc_gate_o}, 2'b10)
      end
      p = s;
    end
    module_req_i <= 4'h4;
    repeat (4) @(posedge sys_clk_i);
    `CHK(src_req_o, 4'h5)
    rd(5'h03, 8'h50, 8'h70);
    module_req_i <= 4'h0;
    $display("source switch done");
    wr(5'h12, 8'hFF);
    rd(5'h12, 8'h0F);
    wr(5'h11, 8'h15);
    rd(5'h11, 8'h15);
    wr(5'h02, 8'h01);
    wr(5'h01, 8'h03);
    wr(5'h00, 8'h01);
    wr(5'h11, 8'h2A);
    rd(5'h01, 8'h0A);
    rd(5'h00, 8'h00);
    rd(5'h11, 8'h15);
    rd(5'h02, 8'h00);
    fuse_freq_sel_i <= 1'b0;
    fuse_cal_lock_i <= 1'b1;
    rst();
    `CHK(frc_ftrim_o, fuse_ftrim16_i)
    rd(5'h12, {4'h8, fuse_ttrim16_i});
    wr(5'h11, 8'h00);
    rd(5'h11, {2'h0, fuse_ftrim16_i});
    wr(5'h01, 8'h03);
    rd(5'h01, 8'h03);
    $display("freeze and lock done");
    tally_and_finish();
  end
endmodule
